//--- rtl/rdm_pkg.sv
// Package of constants and carrier types for the resident DRAM bus slave
// Functional notes
// - Sixteen 4K by 1 chips, 6-bit address halves
// - Capture 16-bit address when sync asserts
// - Respond only to jumper-selected bank 0 or 1
// - Ordinary slave whichever master owns bus
// - RAS asserted two clocks after sync rises, held through sync
// - Row select high passes bits 7-12 first
// - After 150 ns, CAS and column bits 1-6
// - Memory data selected only on read/refresh
// - Read data to processor, bus drivers for DMA
// - Write-type level decides word or byte write
// - Word write asserts both byte strobes
// - Byte write strobe chosen by address bit 0
// - Reply enabled 150 ns after CAS, on din/dout
// - No reply during bus initialize
// - Refresh forces bank selected for any address
// - Refresh is forced read, row only matters
package rdm_pkg;
   localparam int CLK_PERIOD_NS = 20;
   localparam int RAS_TO_CAS_NS = 150;
   localparam int CAS_TO_REPLY_NS = 150;
   localparam int RAS_TO_CAS_CYC = (RAS_TO_CAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAS_TO_REPLY_CYC = (CAS_TO_REPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam int ADDR_W = 16;
   localparam int HALF_W = 6;
   localparam int WORDS = 4096;
   localparam int ROW_LSB = 7;
   localparam int COL_LSB = 1;
   localparam int BANK_LSB = 13;
   localparam logic [2:0] BANK0 = 3'h0;
   localparam logic [2:0] BANK1 = 3'h1;

   typedef enum logic [1:0] {
      RDM_IDLE = 2'b00,
      RDM_ROW = 2'b01,
      RDM_COL = 2'b10,
      RDM_RDY = 2'b11
   } rdm_state_e;

   typedef struct packed {
      logic ras;
      logic cas;
      logic row_column_select;
      logic low_byte_write_strobe;
      logic high_byte_write_strobe;
   } rdm_dram_ctl_s;
endpackage

//--- rtl/rdm_slave.sv
// Resident dynamic memory bus slave with internal 4K x 16 array
`timescale 1ns/1ps
`default_nettype none
module rdm_slave (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [15:0] bdal_i,
   output logic [15:0] bdal_o,
   output logic bdal_oe_o,
   input wire logic bsync_i,
   input wire logic bdin_i,
   input wire logic bdout_i,
   input wire logic bwtbt_i,
   input wire logic bref_i,
   input wire logic binit_i,
   input wire logic dma_master_i,
   input wire logic lower_bank_jumper_i,
   input wire logic upper_bank_jumper_i,
   output logic brply_o,
   output logic [15:0] processor_read_path_o,
   output rdm_pkg::rdm_dram_ctl_s dram_ctl_o,
   output logic [5:0] dram_addr_o
);
   // ****************************************
   // Address capture and bank decode
   // ****************************************
   logic sync_d;
   logic [15:0] addr;
   logic selected;
   logic refresh;
   logic lower_bank_match;
   logic upper_bank_match;
   wire sync_rise = bsync_i && !sync_d;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_d <= 1'b0;
      end else begin
         sync_d <= bsync_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         addr <= 16'h0000;
      end else if (sync_rise) begin
         addr <= bdal_i;
      end
   end

   always_comb begin
      lower_bank_match = addr[15:rdm_pkg::BANK_LSB] == rdm_pkg::BANK0;
      upper_bank_match = addr[15:rdm_pkg::BANK_LSB] == rdm_pkg::BANK1;
   end

   // Refresh level caught with the address; grant/init exclusion is the master's
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         refresh <= 1'b0;
      end else if (sync_rise) begin
         refresh <= bref_i;
      end else if (!bsync_i) begin
         refresh <= 1'b0;
      end
   end

   assign selected = refresh || (lower_bank_jumper_i && lower_bank_match) ||
      (upper_bank_jumper_i && upper_bank_match);

   // ****************************************
   // RAS/CAS sequencing
   // ****************************************
   rdm_pkg::rdm_state_e state;
   rdm_pkg::rdm_state_e next_state;
   logic [rdm_pkg::CNT_W-1:0] cnt;
   logic active;

   assign active = bsync_i && sync_d && selected;

   always_comb begin
      next_state = state;
      case (state)
         rdm_pkg::RDM_IDLE: begin
            if (active) begin
               next_state = rdm_pkg::RDM_ROW;
            end
         end
         rdm_pkg::RDM_ROW: begin
            if (cnt == rdm_pkg::CNT_W'(rdm_pkg::RAS_TO_CAS_CYC - 1)) begin
               next_state = rdm_pkg::RDM_COL;
            end
         end
         rdm_pkg::RDM_COL: begin
            if (cnt == rdm_pkg::CNT_W'(rdm_pkg::CAS_TO_REPLY_CYC - 1)) begin
               next_state = rdm_pkg::RDM_RDY;
            end
         end
         rdm_pkg::RDM_RDY: begin
            next_state = rdm_pkg::RDM_RDY;
         end
         default: begin
            next_state = rdm_pkg::RDM_IDLE;
         end
      endcase
      if (!bsync_i) begin
         next_state = rdm_pkg::RDM_IDLE;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= rdm_pkg::RDM_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= '0;
      end else if (next_state != state) begin
         cnt <= '0;
      end else if (state == rdm_pkg::RDM_ROW || state == rdm_pkg::RDM_COL) begin
         cnt <= cnt + 1'b1;
      end
   end

   // ****************************************
   // DRAM strobes and address mux
   // ****************************************
   logic ras;
   logic cas;
   logic wr_phase;
   logic word_wr;
   logic low_wr;
   logic high_wr;

   assign ras = state != rdm_pkg::RDM_IDLE;
   assign cas = state == rdm_pkg::RDM_COL || state == rdm_pkg::RDM_RDY;
   assign dram_addr_o = cas ? addr[rdm_pkg::COL_LSB +: rdm_pkg::HALF_W] :
      addr[rdm_pkg::ROW_LSB +: rdm_pkg::HALF_W];

   // Write type taken from the write-type level once addressing is done
   assign wr_phase = cas && !refresh && bdout_i;
   assign word_wr = !bwtbt_i;
   assign low_wr = wr_phase && (word_wr || !addr[0]);
   assign high_wr = wr_phase && (word_wr || addr[0]);

   always_comb begin
      dram_ctl_o.ras = ras;
      dram_ctl_o.cas = cas;
      dram_ctl_o.row_column_select = !cas;
      dram_ctl_o.low_byte_write_strobe = low_wr;
      dram_ctl_o.high_byte_write_strobe = high_wr;
   end

   // ****************************************
   // Memory array and read data
   // ****************************************
   logic [15:0] mem [rdm_pkg::WORDS];
   logic [11:0] word_addr;
   logic [15:0] internal_data_path;
   logic rd_sel_n;

   assign word_addr = addr[12:1];

   always_ff @(posedge clk_sys_i) begin
      if (low_wr) begin
         mem[word_addr][7:0] <= bdal_i[7:0];
      end
      if (high_wr) begin
         mem[word_addr][15:8] <= bdal_i[15:8];
      end
   end

   // Select low picks memory data; refresh reads return nothing useful
   assign rd_sel_n = !(cas && bdin_i);
   assign internal_data_path = rd_sel_n ? bdal_i : mem[word_addr];

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         processor_read_path_o <= 16'h0000;
         bdal_o <= 16'h0000;
      end else begin
         processor_read_path_o <= internal_data_path;
         bdal_o <= internal_data_path;
      end
   end

   // ****************************************
   // Reply and bus drivers
   // ****************************************
   logic reply_en;
   assign reply_en = state == rdm_pkg::RDM_RDY && bsync_i && !binit_i;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         brply_o <= 1'b0;
         bdal_oe_o <= 1'b0;
      end else begin
         brply_o <= reply_en && (bdin_i || bdout_i);
         bdal_oe_o <= reply_en && bdin_i && dma_master_i && !refresh;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   logic [rdm_pkg::CNT_W-1:0] cas_age;

   // Cycles since CAS rose, saturating
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cas_age <= '0;
      end else if (!cas) begin
         cas_age <= '0;
      end else if (cas_age != '1) begin
         cas_age <= cas_age + 1'b1;
      end
   end

   ras_holds_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == rdm_pkg::RDM_ROW) |-> ras [*1] ##1 (ras || !bsync_i))
      else $error("RAS dropped while sync held");
   cas_delay_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(ras) |-> !cas [*8] ##1 (cas || !bsync_i))
      else $error("CAS timing wrong");
   rcs_low_cas_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      cas |-> !dram_ctl_o.row_column_select)
      else $error("Row select not low during CAS");
   reply_delay_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(cas) |-> !brply_o [*8])
      else $error("Reply too early after CAS");
   init_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $past(binit_i) |-> !brply_o)
      else $error("Reply during initialize");
   word_strobe_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_phase && !bwtbt_i) |-> (low_wr && high_wr))
      else $error("Word write missing strobe");
   byte_strobe_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_phase && bwtbt_i) |-> (low_wr != high_wr) && (high_wr == addr[0]))
      else $error("Byte strobe wrong");
   sync_end_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      !bsync_i ##1 !bsync_i |-> !ras && !cas && dram_ctl_o.row_column_select && !brply_o)
      else $error("Cycle not closed after sync");
   unsel_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (state == rdm_pkg::RDM_IDLE && !selected) |=> !ras)
      else $error("Unselected bank responded");
   addr_capture_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      sync_rise |=> (addr == $past(bdal_i)))
      else $error("Address not captured at sync");
   ras_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (dram_ctl_o.ras && bsync_i) |=> dram_ctl_o.ras)
      else $error("RAS released before sync");
   bank_hit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (sync_rise && lower_bank_jumper_i && (bdal_i[15:rdm_pkg::BANK_LSB] == rdm_pkg::BANK0))
         |-> ##2 (dram_ctl_o.ras || !bsync_i))
      else $error("Served bank not answered");
   bank_miss_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (sync_rise && !bref_i &&
         !(lower_bank_jumper_i && (bdal_i[15:rdm_pkg::BANK_LSB] == rdm_pkg::BANK0)) &&
         !(upper_bank_jumper_i && (bdal_i[15:rdm_pkg::BANK_LSB] == rdm_pkg::BANK1)))
         |-> ##2 !dram_ctl_o.ras)
      else $error("Unserved bank answered");
   row_addr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (dram_ctl_o.ras && !dram_ctl_o.cas) |-> (dram_ctl_o.row_column_select &&
         (dram_addr_o == addr[rdm_pkg::ROW_LSB +: rdm_pkg::HALF_W])))
      else $error("Row address wrong");
   col_addr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      dram_ctl_o.cas |-> (dram_addr_o == addr[rdm_pkg::COL_LSB +: rdm_pkg::HALF_W]))
      else $error("Column address wrong");
   strobe_cas_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (dram_ctl_o.low_byte_write_strobe || dram_ctl_o.high_byte_write_strobe) |->
         (dram_ctl_o.cas && bdout_i))
      else $error("Write strobe outside write phase");
   reply_comes_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (cas_age >= rdm_pkg::CNT_W'(rdm_pkg::CAS_TO_REPLY_CYC) && bsync_i && !binit_i &&
         (bdin_i || bdout_i)) |=> brply_o)
      else $error("Reply missing");
   reply_age_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      brply_o |-> (cas_age > rdm_pkg::CNT_W'(rdm_pkg::CAS_TO_REPLY_CYC)))
      else $error("Reply before enable delay");
   refresh_sel_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (sync_rise && bref_i) |-> ##2 (dram_ctl_o.ras || !bsync_i))
      else $error("Refresh did not select bank");
   refresh_nowr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      refresh |-> !(dram_ctl_o.low_byte_write_strobe || dram_ctl_o.high_byte_write_strobe))
      else $error("Write during refresh");
   dma_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      bdal_oe_o |-> (brply_o && $past(dma_master_i) && $past(bdin_i)))
      else $error("Bus drivers on outside DMA read");

   // ****************************************
   // Coverage
   // ****************************************
   read_cov_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      brply_o && bdin_i && !refresh);
   write_cov_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      brply_o && bdout_i && bwtbt_i);
   refresh_cov_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      brply_o && refresh);
   word_cov_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      brply_o && bdout_i && !bwtbt_i);
   init_cov_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      binit_i && bdin_i && dram_ctl_o.cas);
endmodule
`default_nettype wire

//--- verif/rdm_master.sv
// Bus master model issuing processor or DMA cycles
`timescale 1ns/1ps
`default_nettype none
module rdm_master (
   input wire logic clk_sys_i,
   input wire logic brply_i,
   input wire logic [15:0] bus_i,
   output logic [15:0] bdal_o,
   output logic bsync_o,
   output logic bdin_o,
   output logic bdout_o,
   output logic bwtbt_o,
   output logic bref_o
);
   initial begin
      bdal_o = 16'h0000;
      {bsync_o, bdin_o, bdout_o, bwtbt_o, bref_o} = 5'h00;
   end
   // Kind: 0 read, 1 word write, 2 byte write, 3 refresh read
   task automatic xfer(input logic [15:0] a, input logic [1:0] k, input logic [15:0] wd,
      output logic [15:0] rd, output logic ok);
      int n;
      logic wr;
      wr = k[1] ^ k[0];
      ok = 1'b0;
      n = 0;
      @(posedge clk_sys_i);
      bdal_o <= a;
      bwtbt_o <= wr;
      bref_o <= k == 2'h3;
      bsync_o <= 1'b1;
      @(posedge clk_sys_i);
      // Released address lines show the inverse
      bdal_o <= wr ? wd : ~a;
      bwtbt_o <= k == 2'h2;
      bdin_o <= !wr;
      bdout_o <= wr;
      while (!ok && n < 40) begin
         @(posedge clk_sys_i);
         ok = brply_i === 1'b1;
         rd = bus_i;
         n++;
      end
      {bsync_o, bdin_o, bdout_o, bwtbt_o, bref_o} <= 5'h00;
      bdal_o <= ~bdal_o;
      repeat (3) @(posedge clk_sys_i);
   endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the resident DRAM bus slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic dma = 1'b1;
   logic binit = 1'b0;
   logic jl = 1'b1;
   logic ju = 1'b0;
   logic [15:0] mb, dq, bus, cp, cp_q, rd;
   logic oe, oe_q, rr, sy, di, dou, wt, rf, rp, ok;
   logic ras_q = 1'b0;
   logic cas_q = 1'b0;
   logic rp_q = 1'b0;
   logic [1:0] str, rcs;
   logic [5:0] da, row, col;
   rdm_pkg::rdm_dram_ctl_s ctl;
   int fail_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int t_ras, t_cas, t_rp;
   assign bus = oe ? dq : mb;
   rdm_master u_m (.clk_sys_i(clk_sys_i), .brply_i(rp), .bus_i(bus), .bdal_o(mb),
      .bsync_o(sy), .bdin_o(di), .bdout_o(dou), .bwtbt_o(wt), .bref_o(rf));
   rdm_slave dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bdal_i(bus), .bdal_o(dq),
      .bdal_oe_o(oe), .bsync_i(sy), .bdin_i(di), .bdout_i(dou), .bwtbt_i(wt), .bref_i(rf),
      .binit_i(binit), .dma_master_i(dma), .lower_bank_jumper_i(jl),
      .upper_bank_jumper_i(ju), .brply_o(rp), .processor_read_path_o(cp),
      .dram_ctl_o(ctl), .dram_addr_o(da));
   initial forever #10 clk_sys_i = ~clk_sys_i;
   // Edge monitor of strobes, addresses and reply
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      ras_q <= ctl.ras;
      cas_q <= ctl.cas;
      rp_q <= rp;
      str <= (ctl.ras && !ras_q) ? 2'h0 :
         str | {ctl.high_byte_write_strobe, ctl.low_byte_write_strobe};
      if (ctl.ras && !ras_q) begin
         t_ras <= cyc;
         row <= da;
         rcs[1] <= ctl.row_column_select;
      end
      if (ctl.cas && !cas_q) begin
         t_cas <= cyc;
         col <= da;
         rcs[0] <= ctl.row_column_select;
      end
      if (rp && !rp_q) begin
         t_rp <= cyc;
         cp_q <= cp;
         {oe_q, rr} <= {oe, ctl.ras};
      end
      if (cyc == 10000) begin
         fail_count++;
         end_of_test();
      end
   end
   task automatic chk_v(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_b(input logic g, input logic e);
      chk_v({15'h0000, g}, {15'h0000, e});
   endtask
   task automatic set(input logic d, input logic i, input logic l, input logic u);
      @(posedge clk_sys_i);
      dma <= d;
      binit <= i;
      jl <= l;
      ju <= u;
   endtask
   task automatic go(input logic [15:0] a, input logic [1:0] k, input logic [15:0] wd);
      u_m.xfer(a, k, wd, rd, ok);
      #1;
   endtask
   task automatic t_word();
      go(16'h0ACE, 2'h1, 16'hA5C3);
      chk_v(16'(str), 16'h0003);
      chk_v(16'(t_cas - t_ras), 16'(rdm_pkg::RAS_TO_CAS_CYC));
      chk_v(16'({row, col}), 16'h0567);
      chk_v(16'(rcs), 16'h0002);
      go(16'h0ACE, 2'h0, 16'h0000);
      chk_v(rd, 16'hA5C3);
      chk_b(oe_q, 1'b1);
      chk_b(rr, 1'b1);
      chk_b((t_rp - t_cas - rdm_pkg::CAS_TO_REPLY_CYC) inside {[0:2]}, 1'b1);
      chk_v({11'h000, ctl}, 16'h0004);
      chk_b(rp, 1'b0);
      $display("word test done");
   endtask
   task automatic t_byte();
      go(16'h0ACE, 2'h1, 16'h0000);
      go(16'h0ACE, 2'h2, 16'h1234);
      chk_v(16'(str), 16'h0001);
      go(16'h0ACF, 2'h2, 16'hABCD);
      chk_v(16'(str), 16'h0002);
      go(16'h0ACE, 2'h0, 16'h0000);
      chk_v(rd, 16'hAB34);
      set(1'b0, 1'b0, 1'b1, 1'b0);
      go(16'h0ACE, 2'h0, 16'h0000);
      chk_b(oe_q, 1'b0);
      chk_v(cp_q, 16'hAB34);
      set(1'b1, 1'b1, 1'b1, 1'b0);
      go(16'h0ACE, 2'h0, 16'h0000);
      chk_b(ok, 1'b0);
      set(1'b1, 1'b0, 1'b1, 1'b0);
      $display("byte test done");
   endtask
   task automatic t_ref();
      int n;
      logic o;
      n = 0;
      o = 1'b0;
      for (int i = 0; i < 64; i++) begin
         go(16'hE000 | 16'(i << 1), 2'h3, 16'h0000);
         n += int'(ok);
         o |= oe_q;
      end
      chk_v(16'(n), 16'h0040);
      chk_b(o, 1'b0);
      go(16'h0ACE, 2'h0, 16'h0000);
      chk_v(rd, 16'hAB34);
      $display("refresh test done");
   endtask
   task automatic t_bank();
      int t;
      t = t_ras;
      go(16'h2AC0, 2'h0, 16'h0000);
      chk_b(ok, 1'b0);
      chk_v(16'(t_ras - t), 16'h0000);
      set(1'b1, 1'b0, 1'b0, 1'b1);
      go(16'h2AC0, 2'h1, 16'h5A5A);
      go(16'h2AC0, 2'h0, 16'h0000);
      chk_v(rd, 16'h5A5A);
      go(16'h0ACE, 2'h0, 16'h0000);
      chk_b(ok, 1'b0);
      $display("bank test done");
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      t_word();
      t_byte();
      t_ref();
      t_bank();
      end_of_test();
   end
endmodule
`default_nettype wire
